// ---- core/ris_pkg.sv ----
/*
   Constants shared by the start-up RAM initialisation sequencer.
   Assumes a single 40 MHz operation clock and a byte-wide buffer RAM.
*/
package ris_pkg;
   // Operation clock
   localparam int          CLK_HZ        = 40_000_000;  // Operation clock rate
   localparam int          CLK_NS        = 25;          // Operation clock period
   // Buffer RAM layout
   localparam int          RAM_AW        = 11;          // Address width
   localparam logic [10:0] MARK_ADDR     = 11'h000;     // Marker byte location
   localparam logic [10:0] ID_ADDR       = 11'h001;     // Station id location
   localparam logic [7:0]  MARK_BYTE     = 8'hD1;       // Marker byte value
   // Completion time for both writes
   localparam int          INIT_DONE_US  = 96;          // Longest time, microseconds
   localparam int          INIT_DONE_CYC = (INIT_DONE_US * 1000) / CLK_NS; // Rounded down
   // Host spacing, in arbitration periods
   localparam int          PTR_GAP_ARB   = 4;           // After pointer low write
   localparam int          DATA_GAP_ARB  = 5;           // Data access to pointer low
   // Micro-program counter range of the init routine
   localparam logic [3:0]  PC_INIT_FIRST = 4'h1;        // First init step
   localparam logic [3:0]  PC_INIT_LAST  = 4'h4;        // Last init step
   localparam int          PC_W          = 4;           // Program counter width
   // Sequencer states
   typedef enum logic [4:0] {
      RIS_IDLE  = 5'b0_0001,
      RIS_SYNC0 = 5'b0_0010,
      RIS_WMARK = 5'b0_0100,
      RIS_SYNC1 = 5'b0_1000,
      RIS_WID   = 5'b1_0000
   } ris_state_t;
endpackage : ris_pkg

// ---- core/ris_ram.sv ----
/*
   Small byte-wide buffer RAM with registered read data.
   Assumes one clock; write and read ports are independent.
*/
`timescale 1ns/10ps
module ris_ram #(
   parameter int AW = 11,
   parameter int DW = 8
) (
   // Clock
   input  wire logic          clk,
   // Write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   // Read port
   input  wire logic [AW-1:0] rd_addr,
   output logic      [DW-1:0] rd_data
);
   logic [DW-1:0] mem [0:(1<<AW)-1];  // Storage

   // Write side
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered read
   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end
endmodule : ris_ram

// ---- core/ris_sequencer.sv ----
/*
   Start-up RAM initialisation sequencer: after the station id is written,
   stores the marker byte and the id in buffer RAM, with an optional
   line-idle wait that the bypass bit can suppress inside the init routine.
   Assumes the host keeps its own access spacing and that line activity
   comes synchronous to clk from the receiver logic.
   Host reads of 000h and 001h before init_done may see stale bytes;
   the RAM has no guard between its write and read ports.
*/
`timescale 1ns/10ps
module ris_sequencer #(
   parameter int DONE_CYC = ris_pkg::INIT_DONE_CYC  // Completion deadline
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // Configuration
   input  wire logic                      init_sync_bypass,
   input  wire logic                      half_rate_arbitration,
   // Station id write from host port
   input  wire logic                      id_wr,
   input  wire logic [7:0]                station_identifier,
   // Line activity from receiver
   input  wire logic                      line_active,
   // Host read path into buffer RAM
   input  wire logic [ris_pkg::RAM_AW-1:0] host_rd_addr,
   output logic      [7:0]                host_rd_data,
   // Status
   output logic                           arb_tick,
   output logic                           init_busy,
   output logic                           init_done,
   output logic                           init_late,
   output logic      [ris_pkg::PC_W-1:0]  prog_counter
);
   ris_pkg::ris_state_t state;        // Current step
   ris_pkg::ris_state_t next_state;   // Following step
   logic [7:0]           id_hold;     // Captured station id
   logic                 arb_phase;   // Half-rate toggle
   logic                 wait_on;     // Line-idle wait effective
   logic                 stall;       // Sequencing stalled
   logic                 ram_we;      // RAM write strobe
   logic [ris_pkg::RAM_AW-1:0] ram_wa; // RAM write address
   logic [7:0]           ram_wd;      // RAM write data
   logic [15:0]          elapsed;     // Cycles since id write

   ////////////////////////////////////////////////////////////////////////
   // Program counter decode
   function automatic logic in_init(input logic [ris_pkg::PC_W-1:0] pc);
      in_init = (pc >= ris_pkg::PC_INIT_FIRST) && (pc <= ris_pkg::PC_INIT_LAST);
   endfunction : in_init

   ////////////////////////////////////////////////////////////////////////
   // Arbitration clock enable
   always_ff @(posedge clk) begin
      if (rst) begin
         // Low phase first, so the first half-rate tick is one cycle on
         arb_phase <= 1'b0;
      end else begin
         // Free-running toggle
         arb_phase <= ~arb_phase;
      end
   end
   // Full rate: every operation cycle is an arbitration period
   assign arb_tick = half_rate_arbitration ? arb_phase : 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Line-idle wait decision
   always_comb begin
      // Bypass suppresses wait only inside the init routine
      // Outside the routine the wait always applies
      wait_on = ~(init_sync_bypass && in_init(prog_counter));
      // Stall only matters in the two wait steps
      stall   = wait_on && line_active;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next step
   always_comb begin
      next_state = state;
      case (state)
         ris_pkg::RIS_IDLE: begin
            // Wait for the host to write the id
            if (id_wr) begin
               next_state = ris_pkg::RIS_SYNC0;
            end
         end
         ris_pkg::RIS_SYNC0: begin
            // Hold here while the line is busy
            if (!stall) begin
               next_state = ris_pkg::RIS_WMARK;
            end
         end
         ris_pkg::RIS_WMARK: begin
            // Marker write takes one cycle
            next_state = ris_pkg::RIS_SYNC1;
         end
         ris_pkg::RIS_SYNC1: begin
            // Second line-idle wait
            if (!stall) begin
               next_state = ris_pkg::RIS_WID;
            end
         end
         ris_pkg::RIS_WID: begin
            // Id written, routine ends
            next_state = ris_pkg::RIS_IDLE;
         end
         default: begin
            // Recover from an illegal code
            next_state = ris_pkg::RIS_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; a new id write restarts the routine
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ris_pkg::RIS_IDLE;
      end else if (id_wr) begin
         // Restart even mid-routine; the newer id replaces the older
         state <= ris_pkg::RIS_SYNC0;
      end else begin
         // Normal advance
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Micro-program counter view of the state
   always_comb begin
      // Codes 1 to 4 mark the init routine, 0 is idle
      case (state)
         ris_pkg::RIS_SYNC0: prog_counter = 4'h1;
         ris_pkg::RIS_WMARK: prog_counter = 4'h2;
         ris_pkg::RIS_SYNC1: prog_counter = 4'h3;
         ris_pkg::RIS_WID:   prog_counter = 4'h4;
         default:            prog_counter = 4'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Station id capture
   always_ff @(posedge clk) begin
      if (rst) begin
         id_hold <= 8'h00;
      end else if (id_wr) begin
         // Latch with the strobe; later bus changes do not matter
         id_hold <= station_identifier;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // RAM write selection
   always_comb begin
      // Default: no write, marker address and byte on the bus
      ram_we = 1'b0;
      ram_wa = ris_pkg::MARK_ADDR;
      ram_wd = ris_pkg::MARK_BYTE;
      if (state == ris_pkg::RIS_WMARK) begin
         // First write: marker byte
         ram_we = 1'b1;
      end else if (state == ris_pkg::RIS_WID) begin
         // Second write: station id
         ram_we = 1'b1;
         ram_wa = ris_pkg::ID_ADDR;
         ram_wd = id_hold;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Completion tracking against the deadline
   always_ff @(posedge clk) begin
      if (rst) begin
         elapsed   <= 16'h0000;
         init_done <= 1'b0;
         init_late <= 1'b0;
      end else if (id_wr) begin
         // A new id restarts the deadline; it beats a same-cycle set,
         // since the routine it would report on is being replaced
         elapsed   <= 16'h0000;
         init_done <= 1'b0;
         init_late <= 1'b0;
      end else if (state == ris_pkg::RIS_WID) begin
         // Both bytes are in RAM after this edge
         init_done <= 1'b1;
      end else if (init_busy) begin
         // Saturating count
         if (elapsed != 16'hFFFF) begin
            elapsed <= elapsed + 16'h0001;
         end
         // Late only after DONE_CYC busy cycles
         if (elapsed >= 16'(DONE_CYC)) begin
            init_late <= 1'b1;
         end
      end
   end
   // Busy whenever the routine is away from idle
   assign init_busy = (state != ris_pkg::RIS_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Buffer RAM
   // Host reads run independently of the sequencer's writes
   ris_ram #(
      .AW (ris_pkg::RAM_AW),
      .DW (8)
   ) u_ram (
      .clk     (clk),
      .wr_en   (ram_we),
      .wr_addr (ram_wa),
      .wr_data (ram_wd),
      .rd_addr (host_rd_addr),
      .rd_data (host_rd_data)
   );
endmodule : ris_sequencer

// ---- verification/ris_sequencer_monitor.sv ----
/*
   Checker on the ports of the init sequencer.
   Assumes a bind to every instance of ris_sequencer.
*/
`timescale 1ns/10ps
module ris_sequencer_monitor (
   // Clock and reset
   input wire logic                      clk,
   input wire logic                      rst,
   // Inputs
   input wire logic                      init_sync_bypass,
   input wire logic                      half_rate_arbitration,
   input wire logic                      id_wr,
   input wire logic                      line_active,
   // Outputs
   input wire logic                      arb_tick,
   input wire logic                      init_busy,
   input wire logic                      init_done,
   input wire logic [ris_pkg::PC_W-1:0]  prog_counter
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Routine sits in a wait step
   wire logic wait_step;
   assign wait_step = init_busy && prog_counter[0] && !id_wr;
   ////////////////////////////////////////////////////////////////
   AST_TICK_FULL: assert property (!half_rate_arbitration |-> arb_tick)
      else $error("tick low at full rate");
   AST_TICK_HALF: assert property (half_rate_arbitration && $past(half_rate_arbitration)
      && !$past(rst) |-> arb_tick != $past(arb_tick)) else $error("tick not alternating");
   AST_START: assert property (id_wr |=> init_busy && prog_counter == 4'h1)
      else $error("routine not started");
   AST_STALL: assert property (wait_step && line_active && !init_sync_bypass
      |=> $stable(prog_counter)) else $error("moved on a busy line");
   AST_IDLE_GO: assert property (wait_step && !line_active
      |=> prog_counter == $past(prog_counter) + 4'h1) else $error("idle line stalled");
   AST_BYPASS: assert property (wait_step && init_sync_bypass
      |=> prog_counter == $past(prog_counter) + 4'h1) else $error("bypass stalled");
   AST_DONE: assert property (id_wr && init_sync_bypass ##1 (!id_wr && init_sync_bypass)[*4]
      |=> init_done && !init_busy) else $error("routine not done");
   // Main scenarios
   cover property (wait_step && line_active && !init_sync_bypass);
   cover property (wait_step && line_active && init_sync_bypass);
   cover property (init_done && !$past(init_done));
endmodule : ris_sequencer_monitor

bind ris_sequencer ris_sequencer_monitor ris_sequencer_monitor_inst (.clk(clk), .rst(rst),
   .init_sync_bypass(init_sync_bypass), .half_rate_arbitration(half_rate_arbitration),
   .id_wr(id_wr), .line_active(line_active), .arb_tick(arb_tick), .init_busy(init_busy),
   .init_done(init_done), .prog_counter(prog_counter));

// ---- verification/ris_host_model.sv ----
/*
   Host controller model: writes the station id, reads buffer RAM.
   Assumes its tasks are called from one bench process.
*/
`timescale 1ns/10ps
module ris_host_model (
   // Clock
   input wire logic                         clk,
   // Host side of the sequencer
   output logic                             id_wr,
   output logic [7:0]                       station_identifier,
   output logic [ris_pkg::RAM_AW-1:0]       host_rd_addr,
   input wire logic [7:0]                   host_rd_data
);
   // Idle values
   initial begin
      id_wr = 1'b0;
      station_identifier = 8'h00;
      host_rd_addr = 11'h000;
   end
   // One-cycle id write, data scrambled once released
   task write_id(input logic [7:0] id);
      @(posedge clk);
      #1 id_wr = 1'b1;
      station_identifier = id;
      @(posedge clk);
      #1 id_wr = 1'b0;
      station_identifier = ~id;
   endtask : write_id
   // Spaced read, data one cycle after address
   task read_byte(input logic [10:0] addr, output logic [7:0] data);
      repeat (2 * ris_pkg::DATA_GAP_ARB) @(posedge clk);
      #1 host_rd_addr = addr;
      @(posedge clk);
      #1 data = host_rd_data;
   endtask : read_byte
endmodule : ris_host_model

// ---- verification/ris_sequencer_tb.sv ----
/*
   Bench for the init sequencer with a host model.
   Assumes a 40 MHz clock and a four-cycle late deadline.
*/
`timescale 1ns/10ps
module ris_sequencer_tb;
   logic clk, rst, init_sync_bypass, half_rate_arbitration, line_active, id_wr;
   logic [7:0]  station_identifier, host_rd_data, rd;
   logic [10:0] host_rd_addr;
   logic        arb_tick, init_busy, init_done, init_late;
   logic [3:0]  prog_counter;
   int          err_count, check_count, n;
   // Device and host
   ris_sequencer #(.DONE_CYC(4)) ris_sequencer_inst (.clk(clk), .rst(rst),
      .init_sync_bypass(init_sync_bypass), .half_rate_arbitration(half_rate_arbitration),
      .id_wr(id_wr), .station_identifier(station_identifier), .line_active(line_active),
      .host_rd_addr(host_rd_addr), .host_rd_data(host_rd_data), .arb_tick(arb_tick),
      .init_busy(init_busy), .init_done(init_done), .init_late(init_late),
      .prog_counter(prog_counter));
   ris_host_model ris_host_model_inst (.clk(clk), .id_wr(id_wr),
      .station_identifier(station_identifier), .host_rd_addr(host_rd_addr),
      .host_rd_data(host_rd_data));
   ////////////////////////////////////////////////////////////////
   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task print_verdict;
      if (err_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   // Bounded wait for completion, cycles in n
   task wait_done;
      n = 0;
      while (init_done !== 1'b1 && n < 60) begin
         @(posedge clk);
         #1 n++;
      end
   endtask : wait_done
   task t_plain;
      ris_host_model_inst.write_id(8'h5A);
      wait_done;
      check(8'(n), 8'h04);
      ris_host_model_inst.read_byte(11'h000, rd);
      check(rd, 8'hD1);
      ris_host_model_inst.read_byte(11'h001, rd);
      check(rd, 8'h5A);
   endtask : t_plain
   task t_stall;
      line_active = 1'b1;
      ris_host_model_inst.write_id(8'hA5);
      repeat (10) @(posedge clk);
      #1 check({7'h00, init_done}, 8'h00);
      check({7'h00, init_late}, 8'h01);
      ris_host_model_inst.read_byte(11'h001, rd);
      check(rd, 8'h5A);
      line_active = 1'b0;
      wait_done;
      ris_host_model_inst.read_byte(11'h001, rd);
      check(rd, 8'hA5);
   endtask : t_stall
   task t_bypass;
      init_sync_bypass = 1'b1;
      line_active = 1'b1;
      ris_host_model_inst.write_id(8'h3C);
      wait_done;
      check(8'(n), 8'h04);
      ris_host_model_inst.read_byte(11'h001, rd);
      check(rd, 8'h3C);
      init_sync_bypass = 1'b0;
      line_active = 1'b0;
   endtask : t_bypass
   // Reset in mid-routine while stalled: all status back to idle, no write
   task t_reset;
      line_active = 1'b1;
      ris_host_model_inst.write_id(8'h77);
      repeat (6) @(posedge clk);
      #1 rst = 1'b1;
      @(posedge clk);
      #1 rst = 1'b0;
      check({7'h00, init_busy}, 8'h00);
      check({7'h00, init_done}, 8'h00);
      check({7'h00, init_late}, 8'h00);
      check({4'h0, prog_counter}, 8'h00);
      line_active = 1'b0;
      ris_host_model_inst.read_byte(11'h001, rd);
      check(rd, 8'h3C);
   endtask : t_reset
   task t_half;
      half_rate_arbitration = 1'b1;
      @(posedge clk);
      #1 rd[0] = arb_tick;
      @(posedge clk);
      #1 check({7'h00, arb_tick}, {7'h00, ~rd[0]});
      half_rate_arbitration = 1'b0;
      @(posedge clk);
      #1 check({7'h00, arb_tick}, 8'h01);
   endtask : t_half
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #50000 err_count++;
      print_verdict;
   end
   initial begin
      {rst, init_sync_bypass, half_rate_arbitration, line_active} = 4'h8;
      err_count = 0;
      check_count = 0;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      t_plain;
      t_stall;
      t_bypass;
      t_reset;
      t_half;
      print_verdict;
   end
endmodule : ris_sequencer_tb
